/* File: bench/atfmt_checker.sv */
// port checker for the tracking sequencer
// assumes the top-level ports only; bound below
`timescale 1ns/1ns
module atfmt_checker
(
	input wire logic       clk,
	input wire logic       nrst,
	input wire logic [7:0] addr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	input wire logic       chip_standby,
	input wire logic       track_enable,
	input wire logic       convert_start
);
default clocking dc @(posedge clk); endclocking
default disable iff (!nrst);
a_standby_track: assert property (chip_standby [*4] |-> !track_enable)
	else $error("tracking in standby");
a_conv_hold: assert property (convert_start |=> !track_enable)
	else $error("tracking while converting");
a_start_pulse: assert property (convert_start |=> !convert_start)
	else $error("start pulse too long");
a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
	else $error("read data without read");
a_rdata_unmap: assert property (rd && addr > 8'h05 |=> rdata == 8'h00)
	else $error("unmapped read not zero");
a_ctrl_upper: assert property (rd && addr == 8'h00 |=> rdata[7:4] == 4'h0)
	else $error("control upper bits set");
a_incfg_upper: assert property (rd && addr == 8'h01 |=> rdata[7:1] == 7'h00)
	else $error("input config upper bits set");
a_status_upper: assert property (rd && addr == 8'h04 |=> rdata[7:3] == 5'h00)
	else $error("status upper bits set");
c_start: cover property (convert_start);
c_standby: cover property (chip_standby && !track_enable);
c_read: cover property (rd && addr == 8'h03);
endmodule
bind atfmt_top atfmt_checker chk_u (.clk(clk), .nrst(nrst), .addr(addr), .rd(rd),
	.rdata(rdata), .chip_standby(chip_standby), .track_enable(track_enable),
	.convert_start(convert_start));

/* File: bench/atfmt_sar_model.sv */
// sar core model: answers each convert_start with a code
// assumes a one-cycle start pulse on the shared clock
`timescale 1ns/1ns
module atfmt_sar_model
#(
	parameter int LAT = 11
)
(
	input  wire logic       clk,
	input  wire logic       go,
	input  wire logic [9:0] code,
	output logic            done,
	output logic [9:0]      q
);
int n = -1;
initial
begin
	done = 1'h0;
	q = 10'h0;
end
// code bus toggles outside the done cycle
// bias generator taken as enabled whenever codes are returned
always @(posedge clk)
begin
	done <= n == 0;
	q <= n == 0 ? code : ~q;
	n <= go ? LAT : (n < 0 ? -1 : n - 1);
end
endmodule

/* File: bench/test_adc_track_hold_result_format.sv */
// bench for the tracking sequencer and result formatter
// assumes the sar model on the far side of the block
`timescale 1ns/1ns
`include "atfmt_defs.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
	$display("Error t=%0t got %h exp %h", $time, g, e); end end
module test_adc_track_hold_result_format;
logic clk = 0, nrst = 0, wr = 0, rd = 0, pin = 0, stby = 0;
logic [7:0] addr = 0, wdata = 0;
logic [9:0] code = 0, q;
logic [7:0] rdata;
logic       trk, cs, sen, done;
logic [7:0] ntrk = 0, ncs = 0;
int         num_errors = 0, n_checks = 0, i;
atfmt_top dut_u (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
	.rdata(rdata), .external_convert_start_pin(pin), .chip_standby(stby), .sar_done(done),
	.sar_code(q), .track_enable(trk), .convert_start(cs), .sar_clk_en(sen));
atfmt_sar_model sar_u (.clk(clk), .go(cs), .code(code), .done(done), .q(q));
initial forever #10 clk = ~clk;
always @(negedge clk)
begin
	ntrk += sen & trk;
	ncs += cs;
end
task wrap_up;
	$display("checks %0d errors %0d", n_checks, num_errors);
	if (num_errors == 0 && n_checks > 0)
		$display("ALL CHECKS OK");
	else
		$display("CHECKS NOT OK");
	$finish;
endtask
task wr_reg(input logic [7:0] a, input logic [7:0] d);
	@(posedge clk) {addr, wdata, wr} <= {a, d, 1'h1};
	@(posedge clk) wr <= 0;
endtask
task rd_chk(input logic [7:0] a, input logic [7:0] e);
	@(posedge clk) {addr, rd} <= {a, 1'h1};
	@(posedge clk) rd <= 0;
	@(negedge clk) `CHK(rdata, e)
endtask
task wait_done;
	for (i = 0; i < 200 && done !== 1'h1; i++)
		@(negedge clk);
	if (i == 200)
	begin
		num_errors++;
		wrap_up;
	end
endtask
task t_conv(input logic [7:0] c, input logic d, input logic [9:0] v, input logic [15:0] e);
	code = v;
	wr_reg(`ATFMT_ADDR_INCFG, {7'h0, d});
	ncs = 0;
	wr_reg(`ATFMT_ADDR_CTRL, c);
	// count from the cycle the new mode is in force
	ntrk = 0;
	wait_done;
	if (c[1]) `CHK(ntrk, 3)
	`CHK(ncs, 1)
	rd_chk(`ATFMT_ADDR_RES_HIGH, e[15:8]);
	rd_chk(`ATFMT_ADDR_STATUS, {5'h00, ~c[1], 2'b01});
	rd_chk(`ATFMT_ADDR_RES_LOW, e[7:0]);
	rd_chk(`ATFMT_ADDR_STATUS, {5'h00, ~c[1], 2'b00});
	`CHK(trk, ~c[1])
	$display("t_conv %h done", c);
endtask
task t_ext;
	code = 10'h155;
	wr_reg(`ATFMT_ADDR_INCFG, 8'h00);
	wr_reg(`ATFMT_ADDR_CTRL, 8'h0b);
	repeat (4) @(posedge clk);
	@(negedge clk) `CHK(trk, 1'h1)
	ncs = 0;
	@(posedge clk) pin <= 1;
	wait_done;
	`CHK(ncs, 1)
	`CHK(trk, 1'h0)
	rd_chk(`ATFMT_ADDR_RES_LOW, 8'h55);
	@(posedge clk) pin <= 0;
	$display("t_ext done");
endtask
task t_stby;
	wr_reg(`ATFMT_ADDR_CTRL, 8'h01);
	@(posedge clk) stby <= 1;
	repeat (5) @(posedge clk);
	@(negedge clk) `CHK(trk, 1'h0)
	@(posedge clk) stby <= 0;
	repeat (5) @(posedge clk);
	@(negedge clk) `CHK(trk, 1'h1)
	$display("t_stby done");
endtask
initial
begin
	repeat (16) @(posedge clk);
	nrst <= 1;
	repeat (3) @(posedge clk);
	rd_chk(`ATFMT_ADDR_CTRL, `ATFMT_CTRL_RESET);
	rd_chk(`ATFMT_ADDR_SARDIV, `ATFMT_SARDIV_RESET);
	wr_reg(8'h10, 8'h5a);
	rd_chk(8'h10, 8'h00);
	wr_reg(`ATFMT_ADDR_CTRL, 8'he4);
	rd_chk(`ATFMT_ADDR_CTRL, 8'h04);
	t_conv(8'h11, 0, 10'h3ff, 16'h03ff);
	t_conv(8'h17, 0, 10'h3ff, 16'hffc0);
	t_conv(8'h13, 0, 10'h200, 16'h0200);
	t_conv(8'h15, 0, 10'h200, 16'h8000);
	t_conv(8'h11, 1, 10'h1ff, 16'h01ff);
	t_conv(8'h17, 1, 10'h1ff, 16'h7fc0);
	t_conv(8'h13, 1, 10'h200, 16'hfe00);
	t_ext;
	t_stby;
	wrap_up;
end
endmodule

/* File: common/atfmt_defs.vh */
// constants for the track-and-hold sequencer and result formatter
// assumes inclusion by bare name from logic files
`ifndef ATFMT_DEFS_VH
`define ATFMT_DEFS_VH

// ============================================================
// register offsets (8-bit address)
`define ATFMT_ADDR_CTRL      8'h00
`define ATFMT_ADDR_INCFG     8'h01
`define ATFMT_ADDR_RES_HIGH  8'h02
`define ATFMT_ADDR_RES_LOW   8'h03
`define ATFMT_ADDR_STATUS    8'h04
`define ATFMT_ADDR_SARDIV    8'h05

// ============================================================
// control register fields and register reset values
`define ATFMT_CTRL_ENABLE    0
`define ATFMT_CTRL_TRACKMODE 1
`define ATFMT_CTRL_LJUST     2
`define ATFMT_CTRL_EXTSTART  3
`define ATFMT_CTRL_START     4
`define ATFMT_CTRL_RESET     8'h00
`define ATFMT_SARDIV_RESET   8'h01

// ============================================================
// timing counts in SAR clocks; result width in bits
`define ATFMT_TRACK_SAR      4'd3
`define ATFMT_CONV_SAR       4'd11
`define ATFMT_RES_BITS       10

`endif

/* File: logic/atfmt_format.v */
// result formatter: packs a 10-bit code into high and low result bytes
// assumes code and flags are stable when load is pulsed; same clock
`timescale 1ns/1ns
`include "atfmt_defs.vh"

module atfmt_format
(
	input  wire       clk,
	input  wire       rst_n,
	input  wire       load,
	input  wire [9:0] code,
	input  wire       left_justify_select,
	input  wire       differential,
	output reg  [7:0] result_high_byte,
	output reg  [7:0] result_low_byte
);

	reg [15:0] next_word;

	always @*
	begin
		if (left_justify_select)
			next_word = {code, 6'h00}; // RULE8 RULE10
		else if (differential)
			next_word = {{6{code[9]}}, code}; // RULE10
		else
			next_word = {6'h00, code}; // RULE9
	end

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			result_high_byte <= 8'h00;
			result_low_byte  <= 8'h00;
		end
		else if (load)
		begin
			result_high_byte <= next_word[15:8];
			result_low_byte  <= next_word[7:0];
		end
	end

endmodule

/* File: logic/atfmt_top.v */
// track-and-hold sequencer with register port and result formatting
// assumes an external SAR core answers with a 10-bit code when done
`timescale 1ns/1ns
`include "atfmt_defs.vh"

// Summary of operation
// (RULE1) one control bit picks continuous or low-power tracking
// (RULE2) mode bit clear: track input whenever not converting
// (RULE3) mode bit set: three SAR clocks of tracking after each start
// (RULE4) low-power with pin start: track only while start pin is low
// (RULE5) conversion begins on the rising edge of the start pin
// (RULE6) tracking shuts down while the chip is in standby or sleep
// (RULE7) software picks low-power mode when mux or gain change often
// (RULE8) left-justified: result in high byte and low bits 7:6, rest zero
// (RULE9) right-justified: result right-aligned, full scale 0x03ff
// (RULE10) differential input reports signed two's complement
// (RULE11) software enables the bias generator whenever converters run
module atfmt_top
(
	input  wire       clk,
	input  wire       nrst,
	input  wire [7:0] addr,
	input  wire [7:0] wdata,
	input  wire       wr,
	input  wire       rd,
	output reg  [7:0] rdata,
	input  wire       external_convert_start_pin,
	input  wire       chip_standby,
	input  wire       sar_done,
	input  wire [9:0] sar_code,
	output wire       track_enable,
	output wire       convert_start,
	output wire       sar_clk_en
);

	localparam ST_IDLE  = 2'd0;
	localparam ST_TRACK = 2'd1;
	localparam ST_CONV  = 2'd2;

	// ============================================================
	// reset release and pin synchronisers
	reg  [1:0] rst_sync;
	wire       rst_n = rst_sync[1];
	reg  [1:0] cnv_sync;
	reg  [1:0] stby_sync;
	reg        cnv_prev;

	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			rst_sync <= 2'b00;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnv_sync  <= 2'b00;
			stby_sync <= 2'b00;
			cnv_prev  <= 1'b0;
		end
		else
		begin
			cnv_sync  <= {cnv_sync[0], external_convert_start_pin};
			stby_sync <= {stby_sync[0], chip_standby};
			cnv_prev  <= cnv_sync[1];
		end
	end

	wire pin_rise = cnv_sync[1] & ~cnv_prev;
	wire standby  = stby_sync[1];

	// ============================================================
	// registers
	reg  [7:0] converter_control_reg;
	reg  [7:0] input_pair_config;
	reg  [7:0] sar_div;
	reg  [1:0] state;
	reg  [3:0] sar_cnt;
	reg  [7:0] div_cnt;
	reg        done_flag;
	wire [7:0] result_high_byte;
	wire [7:0] result_low_byte;

	wire enable              = converter_control_reg[`ATFMT_CTRL_ENABLE];
	wire track_mode_select   = converter_control_reg[`ATFMT_CTRL_TRACKMODE]; // RULE1
	wire left_justify_select = converter_control_reg[`ATFMT_CTRL_LJUST];
	wire ext_start           = converter_control_reg[`ATFMT_CTRL_EXTSTART];
	// a start written together with new mode bits obeys the new bits
	wire       ctrl_wr  = wr && (addr == `ATFMT_ADDR_CTRL);
	wire [3:0] ctrl_now = ctrl_wr ? wdata[3:0] : converter_control_reg[3:0];
	wire       lp_now   = ctrl_now[`ATFMT_CTRL_TRACKMODE] && !ctrl_now[`ATFMT_CTRL_EXTSTART];
	wire sw_start  = ctrl_wr && wdata[`ATFMT_CTRL_START];
	wire start_evt = ctrl_now[`ATFMT_CTRL_ENABLE]
		&& (ctrl_now[`ATFMT_CTRL_EXTSTART] ? pin_rise : sw_start);
	wire load      = (state == ST_CONV) && sar_done;

	// ============================================================
	// SAR clock enable divider
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			div_cnt <= 8'h00;
		else if (div_cnt >= sar_div)
			div_cnt <= 8'h00;
		else
			div_cnt <= div_cnt + 8'h01;
	end

	assign sar_clk_en = (div_cnt >= sar_div);

	// ============================================================
	// sequencer
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state   <= ST_IDLE;
			sar_cnt <= 4'h0;
		end
		else
		begin
			case (state)
				ST_IDLE:
				begin
					if (start_evt && lp_now)
					begin
						state   <= ST_TRACK; // RULE3
						sar_cnt <= 4'h0;
					end
					else if (start_evt)
						state <= ST_CONV; // RULE5
				end
				ST_TRACK:
				begin
					if (sar_clk_en)
					begin
						if (sar_cnt == `ATFMT_TRACK_SAR - 4'd1)
							state <= ST_CONV; // RULE3
						sar_cnt <= sar_cnt + 4'h1;
					end
				end
				ST_CONV:
				begin
					if (sar_done)
						state <= ST_IDLE;
				end
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	assign convert_start = (state == ST_TRACK && sar_clk_en
		&& sar_cnt == `ATFMT_TRACK_SAR - 4'd1)
		|| (state == ST_IDLE && start_evt && !lp_now);

	// continuous when mode clear; low-power tracks only in window or pin low
	assign track_enable = enable && !standby && ( // RULE6
		!track_mode_select ? (state == ST_IDLE) : // RULE2
		ext_start ? (state == ST_IDLE && !cnv_sync[1]) : // RULE4
		(state == ST_TRACK)); // RULE3

	// ============================================================
	// register port
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			converter_control_reg <= `ATFMT_CTRL_RESET;
			input_pair_config     <= 8'h00;
			sar_div               <= `ATFMT_SARDIV_RESET;
			done_flag             <= 1'b0;
			rdata                 <= 8'h00;
		end
		else
		begin
			if (wr && addr == `ATFMT_ADDR_CTRL)
				converter_control_reg <= {4'h0, wdata[3:0]};
			if (wr && addr == `ATFMT_ADDR_INCFG)
				input_pair_config <= {7'h00, wdata[0]};
			if (wr && addr == `ATFMT_ADDR_SARDIV)
				sar_div <= wdata;
			// set wins over the clear on read of the low byte
			if (load)
				done_flag <= 1'b1;
			else if (rd && addr == `ATFMT_ADDR_RES_LOW)
				done_flag <= 1'b0;
			rdata <= 8'h00;
			if (rd)
			begin
				case (addr)
					`ATFMT_ADDR_CTRL:     rdata <= converter_control_reg;
					`ATFMT_ADDR_INCFG:    rdata <= input_pair_config;
					`ATFMT_ADDR_RES_HIGH: rdata <= result_high_byte;
					`ATFMT_ADDR_RES_LOW:  rdata <= result_low_byte;
					`ATFMT_ADDR_STATUS:   rdata <= {5'h00, track_enable,
						state != ST_IDLE, done_flag};
					`ATFMT_ADDR_SARDIV:   rdata <= sar_div;
					default:              rdata <= 8'h00;
				endcase
			end
		end
	end

	atfmt_format u_format
	(
		.clk                 (clk),
		.rst_n               (rst_n),
		.load                (load),
		.code                (sar_code),
		.left_justify_select (left_justify_select),
		.differential        (input_pair_config[0]), // RULE10
		.result_high_byte    (result_high_byte),
		.result_low_byte     (result_low_byte)
	);

endmodule
